// >>> src/tmc_pkg.sv
/*
  Shared constants for one timer channel: register addresses, field
  positions, reset values and operating mode codes.
  Assumes an 8-bit register port with 20-bit byte addresses.
*/
package tmc_pkg;

  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 8;

  // Mode byte and overflow status addresses, per channel
  localparam logic [19:0] MODE_LOW_ADDR_CH0 = 20'hF0190;
  localparam logic [19:0] MODE_LOW_ADDR_CH1 = 20'hF0192;
  localparam logic [19:0] OVF_STATUS_ADDR_CH0 = 20'hF01A0;
  localparam logic [19:0] OVF_STATUS_ADDR_CH1 = 20'hF01A2;

  // Field positions in the mode low byte
  localparam int unsigned START_BEHAV_POS = 0;
  localparam int unsigned OP_MODE_LSB = 1;
  localparam int unsigned EDGE_SEL_LSB = 6;
  localparam logic [7:0] MODE_LOW_WR_MASK = 8'hCF;

  // Field position in the overflow status byte
  localparam int unsigned OVF_FLAG_POS = 0;

  localparam logic [7:0] MODE_LOW_RESET = 8'h00;
  localparam logic [7:0] OVF_STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Operating mode codes (op_mode_bit2..op_mode_bit0)
  localparam logic [2:0] MODE_INTERVAL = 3'h0;
  localparam logic [2:0] MODE_CAPTURE = 3'h2;
  localparam logic [2:0] MODE_EVENT = 3'h3;
  localparam logic [2:0] MODE_ONE_COUNT = 3'h4;
  localparam logic [2:0] MODE_CAP_ONE = 3'h6;

  // Input edge selection codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_LOW_WIDTH = 2'h2;
  localparam logic [1:0] EDGE_HIGH_WIDTH = 2'h3;

  // Synchroniser depth for the timer input pin
  localparam int unsigned PIN_SYNC_STAGES = 3;

endpackage

// >>> src/tmc_pin_sync.sv
/*
  Three-stage synchroniser for the timer input pin with edge pulses.
  Assumes the pin is asynchronous to core_clk; a change is accepted
  once the second and third stage agree.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_pin_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic level,
  output logic rise,
  output logic fall
);

  logic [tmc_pkg::PIN_SYNC_STAGES-1:0] sync_q;
  logic level_q;
  logic rise_q;
  logic fall_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[tmc_pkg::PIN_SYNC_STAGES-2:0], pin_in};
    end
  end

  // Only stages two and three are compared; stage one feeds stage two alone
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (sync_q[1] == sync_q[2] && sync_q[2] != level_q) begin
        level_q <= sync_q[2];
        rise_q <= sync_q[2];
        fall_q <= ~sync_q[2];
      end
    end
  end

  assign level = level_q;
  assign rise = rise_q;
  assign fall = fall_q;

endmodule

`default_nettype wire

// >>> src/tmc_channel.sv
/*
  One timer channel: mode byte, counter in five operating modes, start
  behaviour handling and the capture overflow status byte.
  Assumes start, stop and count tick pulses come from logic on core_clk,
  and the reload value from the channel data register outside.
*/
`timescale 1ns/1ps
`default_nettype none

module tmc_channel #(
  parameter int unsigned CNT_W = 16,
  parameter bit CHANNEL = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [tmc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [tmc_pkg::DATA_W-1:0] reg_wdata,
  output logic [tmc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic channel_start_trigger,
  input wire logic channel_stop_trigger,
  input wire logic count_tick,
  input wire logic [CNT_W-1:0] load_value,
  input wire logic timer_in_pin,
  output logic channel_irq,
  output logic channel_timer_out,
  output logic counting,
  output logic [CNT_W-1:0] channel_counter,
  output logic [CNT_W-1:0] capture_value
);

  localparam logic [19:0] MODE_ADDR = CHANNEL ? tmc_pkg::MODE_LOW_ADDR_CH1 : tmc_pkg::MODE_LOW_ADDR_CH0;
  localparam logic [19:0] OVF_ADDR = CHANNEL ? tmc_pkg::OVF_STATUS_ADDR_CH1 : tmc_pkg::OVF_STATUS_ADDR_CH0;

  logic [7:0] channel_mode_low_byte_q;
  logic [7:0] reg_rdata_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cap_q;
  logic run_q;
  logic ovf_pending_q;
  logic capture_overflow_flag_q;
  logic irq_q;
  logic tout_q;

  logic pin_level;
  logic pin_rise;
  logic pin_fall;

  logic [2:0] op_mode;
  logic start_behaviour_bit;
  logic [1:0] edge_sel;
  logic mode_up;
  logic mode_down;
  logic mode_capture_kind;
  logic cnt_zero;
  logic cnt_all_ones;
  logic sw_start_ok;
  logic pin_start_ok;
  logic start_acc;
  logic start_fresh;
  logic start_irq;
  logic cap_hit;
  logic up_tick;
  logic dn_tick;
  logic wrap;
  logic dn_expire;

  // Picks the selected edge; width modes start on one edge, capture on the other
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall,
                                    input logic is_start);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      tmc_pkg::EDGE_FALL: hit = fall;
      tmc_pkg::EDGE_RISE: hit = rise;
      tmc_pkg::EDGE_LOW_WIDTH: hit = is_start ? fall : rise;
      tmc_pkg::EDGE_HIGH_WIDTH: hit = is_start ? rise : fall;
    endcase
    return hit;
  endfunction

  tmc_pin_sync u_pin_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(timer_in_pin),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign op_mode = channel_mode_low_byte_q[tmc_pkg::OP_MODE_LSB +: 3];
  assign start_behaviour_bit = channel_mode_low_byte_q[tmc_pkg::START_BEHAV_POS];
  assign edge_sel = channel_mode_low_byte_q[tmc_pkg::EDGE_SEL_LSB +: 2];

  // Direction per mode; prohibited codes neither count nor start
  always_comb begin
    mode_up = 1'b0;
    mode_down = 1'b0;
    unique case (op_mode)
      tmc_pkg::MODE_INTERVAL: mode_down = 1'b1;
      tmc_pkg::MODE_CAPTURE: mode_up = 1'b1;
      tmc_pkg::MODE_EVENT: mode_down = 1'b1;
      tmc_pkg::MODE_ONE_COUNT: mode_down = 1'b1;
      tmc_pkg::MODE_CAP_ONE: mode_up = 1'b1;
      default: begin
        mode_up = 1'b0;
        mode_down = 1'b0;
      end
    endcase
  end

  assign mode_capture_kind = (op_mode == tmc_pkg::MODE_CAPTURE) || (op_mode == tmc_pkg::MODE_CAP_ONE);
  assign cnt_zero = (cnt_q == '0);
  assign cnt_all_ones = (cnt_q == {CNT_W{1'b1}});

  // Software start: fresh start taken in every defined mode; a start while running depends on mode
  always_comb begin
    sw_start_ok = 1'b0;
    if (channel_start_trigger && (mode_up || mode_down)) begin
      if (!run_q) begin
        sw_start_ok = 1'b1;
      end else if (op_mode == tmc_pkg::MODE_ONE_COUNT) begin
        sw_start_ok = start_behaviour_bit;
      end else if (op_mode == tmc_pkg::MODE_CAP_ONE) begin
        sw_start_ok = 1'b0;
      end else begin
        sw_start_ok = 1'b1;
      end
    end
  end

  // Capture and one-count also starts on the pin's start edge while idle
  assign pin_start_ok = !run_q && (op_mode == tmc_pkg::MODE_CAP_ONE) &&
                        edge_hit(edge_sel, pin_rise, pin_fall, 1'b1);
  assign start_acc = sw_start_ok || pin_start_ok;
  assign start_fresh = start_acc && !run_q;

  // Only interval and capture modes use the start bit at count start
  assign start_irq = start_fresh && start_behaviour_bit &&
                     ((op_mode == tmc_pkg::MODE_INTERVAL) || (op_mode == tmc_pkg::MODE_CAPTURE));

  assign cap_hit = run_q && !start_acc && mode_capture_kind &&
                   edge_hit(edge_sel, pin_rise, pin_fall, op_mode != tmc_pkg::MODE_CAP_ONE);
  assign up_tick = run_q && !start_acc && mode_up && count_tick;
  assign wrap = up_tick && cnt_all_ones;
  assign dn_tick = run_q && !start_acc && mode_down &&
                   ((op_mode == tmc_pkg::MODE_EVENT) ? edge_hit(edge_sel, pin_rise, pin_fall, 1'b1)
                                                     : count_tick);
  assign dn_expire = dn_tick && cnt_zero;

  // Register port: mode byte is read/write, status byte read-only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      channel_mode_low_byte_q <= tmc_pkg::MODE_LOW_RESET;
    end else if (reg_wr && reg_addr == MODE_ADDR) begin
      channel_mode_low_byte_q <= reg_wdata & tmc_pkg::MODE_LOW_WR_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= tmc_pkg::UNMAPPED_READ;
    end else if (reg_rd) begin
      if (reg_addr == MODE_ADDR) begin
        reg_rdata_q <= channel_mode_low_byte_q;
      end else if (reg_addr == OVF_ADDR) begin
        reg_rdata_q <= {7'h00, capture_overflow_flag_q};
      end else begin
        reg_rdata_q <= tmc_pkg::UNMAPPED_READ;
      end
    end
  end

  // Counter, run state and captured value
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      cap_q <= '0;
      run_q <= 1'b0;
    end else if (start_acc) begin
      cnt_q <= mode_up ? '0 : load_value;
      run_q <= 1'b1;
    end else if (channel_stop_trigger) begin
      run_q <= 1'b0;
    end else if (cap_hit) begin
      cap_q <= cnt_q;
      cnt_q <= '0;
      if (op_mode == tmc_pkg::MODE_CAP_ONE) begin
        run_q <= 1'b0;
      end
    end else if (up_tick) begin
      cnt_q <= CNT_W'(cnt_q + 1'b1);
    end else if (dn_tick) begin
      if (cnt_zero) begin
        cnt_q <= load_value;
        if (op_mode == tmc_pkg::MODE_ONE_COUNT) begin
          run_q <= 1'b0;
        end
      end else begin
        cnt_q <= CNT_W'(cnt_q - 1'b1);
      end
    end
  end

  // Overflow is only remembered here; the flag moves at capture time
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovf_pending_q <= 1'b0;
    end else if (!mode_capture_kind) begin
      ovf_pending_q <= 1'b0;
    end else if (cap_hit) begin
      ovf_pending_q <= 1'b0;
    end else if (wrap) begin
      ovf_pending_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      capture_overflow_flag_q <= 1'b0;
    end else if (cap_hit && mode_capture_kind) begin
      capture_overflow_flag_q <= ovf_pending_q;
    end
  end

  // Interrupt pulse and timer output
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= start_irq || cap_hit || dn_expire;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tout_q <= 1'b0;
    end else if (start_irq) begin
      tout_q <= ~tout_q;
    end else if (dn_expire && ((op_mode == tmc_pkg::MODE_INTERVAL) || (op_mode == tmc_pkg::MODE_ONE_COUNT))) begin
      tout_q <= ~tout_q;
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign channel_irq = irq_q;
  assign channel_timer_out = tout_q;
  assign counting = run_q;
  assign channel_counter = cnt_q;
  assign capture_value = cap_q;

endmodule

`default_nettype wire

// >>> tb/tmc_channel_monitor.sv
/*
  Checker for one timer channel, bound to every tmc_channel.
  Assumes software writes only the defined mode codes.
*/
`timescale 1ns/1ps
`default_nettype none
module tmc_channel_monitor #(
  parameter int unsigned CNT_W = 16,
  parameter bit CHANNEL = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [tmc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [tmc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [tmc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic channel_start_trigger,
  input wire logic channel_stop_trigger,
  input wire logic count_tick,
  input wire logic [CNT_W-1:0] load_value,
  input wire logic channel_irq,
  input wire logic channel_timer_out,
  input wire logic counting,
  input wire logic [CNT_W-1:0] channel_counter
);
  localparam logic [19:0] MODE_A = CHANNEL ? tmc_pkg::MODE_LOW_ADDR_CH1 : tmc_pkg::MODE_LOW_ADDR_CH0;
  localparam logic [19:0] STAT_A = CHANNEL ? tmc_pkg::OVF_STATUS_ADDR_CH1 : tmc_pkg::OVF_STATUS_ADDR_CH0;
  logic [3:0] mode_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_q <= 4'h0;
    end else if (reg_wr && reg_addr == MODE_A) begin
      mode_q <= reg_wdata[3:0];
    end
  end
  wire logic run_tick = counting && count_tick && !channel_start_trigger && !channel_stop_trigger;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_fresh;
    channel_start_trigger && !counting && !channel_stop_trigger;
  endsequence
  property p_status_rd;
    reg_rd && reg_addr == STAT_A |=> reg_rdata[7:1] == 7'h00;
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status upper bits set");
  property p_irq_start;
    s_fresh ##0 (mode_q == 4'h1 || mode_q == 4'h5) |=> channel_irq && channel_timer_out != $past(channel_timer_out);
  endproperty
  a_irq_start: assert property (p_irq_start) else $error("no start interrupt");
  property p_no_irq;
    s_fresh ##0 (mode_q == 4'h0 || mode_q == 4'h4) |=> !channel_irq && $stable(channel_timer_out);
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("unexpected start interrupt");
  property p_one_start;
    s_fresh ##0 mode_q[3:1] == 3'h4 |=> !channel_irq && $stable(channel_timer_out);
  endproperty
  a_one_start: assert property (p_one_start) else $error("one-count start touched irq");
  property p_one_ignore;
    channel_start_trigger && counting && mode_q == 4'h8 && !channel_stop_trigger && !count_tick
      |=> !channel_irq && $stable(channel_counter);
  endproperty
  a_one_ignore: assert property (p_one_ignore) else $error("restart not ignored");
  property p_one_restart;
    channel_start_trigger && counting && mode_q == 4'h9 && !channel_stop_trigger
      |=> channel_counter == $past(load_value) && !channel_irq;
  endproperty
  a_one_restart: assert property (p_one_restart) else $error("restart not reloaded");
  property p_down;
    run_tick && channel_counter != '0 && (mode_q[3:1] == 3'h0 || mode_q[3:1] == 3'h4)
      |=> channel_counter == $past(channel_counter) - 1'b1;
  endproperty
  a_down: assert property (p_down) else $error("counter not counting down");
  property p_up;
    run_tick && (mode_q[3:1] == 3'h2 || mode_q[3:1] == 3'h6)
      |=> channel_counter == $past(channel_counter) + 1'b1 || channel_counter == '0;
  endproperty
  a_up: assert property (p_up) else $error("counter not counting up");
endmodule
bind tmc_channel tmc_channel_monitor #(.CNT_W(CNT_W), .CHANNEL(CHANNEL)) u_mon (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .channel_start_trigger(channel_start_trigger),
  .channel_stop_trigger(channel_stop_trigger), .count_tick(count_tick), .load_value(load_value),
  .channel_irq(channel_irq), .channel_timer_out(channel_timer_out), .counting(counting),
  .channel_counter(channel_counter));
`default_nettype wire

// >>> tb/tmc_pin_model.sv
/*
  Timer input pin source: idles low, gives single pulses on request.
  Assumes the channel samples the pin on its own clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_model (
  output var logic pin
);
  initial pin = 1'b0;
  // Ten clocks each way, well past the synchroniser
  task automatic pulse();
    pin = 1'b1;
    #40;
    pin = 1'b0;
    #40;
  endtask
endmodule
`default_nettype wire

// >>> tb/timer_channel_mode_overflow_tb_top.sv
/*
  Self-checking bench for one timer channel with a 4-bit counter.
  Assumes the pin model in tmc_pin_model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_channel_mode_overflow_tb_top;
  localparam logic [19:0] MA = tmc_pkg::MODE_LOW_ADDR_CH0;
  localparam logic [19:0] SA = tmc_pkg::OVF_STATUS_ADDR_CH0;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [19:0] reg_addr = 20'h00000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic start_t = 1'b0;
  logic stop_t = 1'b0;
  logic tick = 1'b0;
  logic [3:0] load = 4'h3;
  logic pin;
  logic irq;
  logic tout;
  logic counting;
  logic [3:0] cnt;
  logic [3:0] cap;
  int fail_count = 0;
  int checks = 0;
  always #2 core_clk = ~core_clk;
  tmc_channel #(.CNT_W(4), .CHANNEL(1'b0)) u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .channel_start_trigger(start_t), .channel_stop_trigger(stop_t), .count_tick(tick), .load_value(load),
    .timer_in_pin(pin), .channel_irq(irq), .channel_timer_out(tout), .counting(counting),
    .channel_counter(cnt), .capture_value(cap));
  tmc_pin_model u_pin (.pin(pin));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask
  task automatic go(input logic s, input logic t, input int n);
    repeat (n) begin
      @(negedge core_clk);
      start_t = s;
      tick = t;
      @(negedge core_clk);
      start_t = 1'b0;
      tick = 1'b0;
    end
  endtask
  task automatic halt();
    @(negedge core_clk);
    stop_t = 1'b1;
    @(negedge core_clk);
    stop_t = 1'b0;
  endtask
  task automatic capture(input logic [3:0] ecap, input logic [7:0] eflag);
    u_pin.pulse();
    repeat (10) @(negedge core_clk);
    chk(8'(cap), 8'(ecap));
    rd(SA, eflag);
  endtask
  task automatic t_regs();
    rd(SA, 8'h00);
    rd(MA, 8'h00);
    rd(20'hF0100, 8'h00);
    wr(SA, 8'hFF);
    rd(SA, 8'h00);
  endtask
  task automatic t_interval();
    wr(MA, 8'h01);
    go(1'b1, 1'b0, 1);
    chk(8'(irq), 8'h01);
    chk(8'(cnt), 8'h03);
    go(1'b0, 1'b1, 1);
    chk(8'(cnt), 8'h02);
    halt();
  endtask
  task automatic t_one();
    wr(MA, 8'h08);
    go(1'b1, 1'b0, 1);
    chk(8'(irq), 8'h00);
    go(1'b0, 1'b1, 1);
    go(1'b1, 1'b0, 1);
    chk(8'(cnt), 8'h02);
    chk(8'(irq), 8'h00);
    halt();
    wr(MA, 8'h09);
    go(1'b1, 1'b0, 1);
    go(1'b0, 1'b1, 1);
    go(1'b1, 1'b0, 1);
    chk(8'(cnt), 8'h03);
    chk(8'(irq), 8'h00);
    halt();
  endtask
  task automatic t_capture();
    wr(MA, 8'h44);
    rd(MA, 8'h44);
    go(1'b1, 1'b0, 1);
    chk(8'(cnt), 8'h00);
    go(1'b0, 1'b1, 2);
    capture(4'h2, 8'h00);
    go(1'b0, 1'b1, 18);
    rd(SA, 8'h00);
    capture(4'h2, 8'h01);
    go(1'b0, 1'b1, 3);
    capture(4'h3, 8'h00);
    halt();
  endtask
  task automatic t_cap_one();
    logic t0;
    wr(MA, 8'hCC);
    t0 = tout;
    fork
      u_pin.pulse();
      go(1'b0, 1'b1, 4);
    join
    repeat (4) @(negedge core_clk);
    chk(8'(counting), 8'h00);
    chk(8'(tout), 8'(t0));
    rd(SA, 8'h00);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    t_regs();
    t_interval();
    t_one();
    t_capture();
    t_cap_one();
    tally_and_finish();
  end
  // Whole run is under 500 clocks
  initial begin
    #20000;
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
